// File: verilog/pwr_events_consts.svh
// Register offsets, field positions, event codes and reset values.
`ifndef PWR_EVENTS_CONSTS_SVH
`define PWR_EVENTS_CONSTS_SVH
`define OFS_SETUP0 6'h00
`define OFS_COUNT_LO0 6'h10
`define OFS_COUNT_HI0 6'h20
`define OFS_FILTER_LO 6'h30
`define OFS_FILTER_HI 6'h31
`define OFS_TALLY 6'h32
`define SETUP_SEL_LSB 0
`define SETUP_SEL_MSB 7
`define SETUP_EDGE_BIT 18
`define SETUP_EN_BIT 22
`define SETUP_INV_BIT 23
`define SETUP_THR_LSB 24
`define SETUP_THR_MSB 31
`define SETUP_RESET 32'h0000_0000
`define FILTER_RESET 32'h0000_0000
`define EV_NOTHING 8'h00
`define EV_CLOCK 8'h01
`define EV_VOLT_TRANS 8'h03
`define EV_THERM_LIMIT 8'h04
`define EV_POWER_LIMIT 8'h05
`define EV_BAND0 8'h0b
`define EV_BAND1 8'h0c
`define EV_BAND2 8'h0d
`define EV_BAND3 8'h0e
`define EV_LIGHT_CROSS 8'h11
`define EV_HEAVY_CROSS 8'h12
`define EV_PKG_ACTIVE 8'h2a
`define EV_PKG_DEEP 8'h2d
`define EV_MEM_SHED 8'h2f
`define EV_ACTIVE_TALLY 8'h35
`define EV_SLEEP_TALLY 8'h37
`define EV_CSTATE_TRANS 8'h72
`define EV_IO_LIMIT 8'h73
`define EV_FREQ_CHANGE 8'h74
`define EV_OCC_ACTIVE 8'h80
`endif

// File: verilog/pwr_events_pkg.sv
// Types shared by the power unit event counters.
package pwr_events_pkg;
  typedef logic [7:0] event_code_t;
  typedef logic [3:0] tally_t;
  typedef logic [7:0] band_t;
endpackage : pwr_events_pkg

// File: verilog/power_unit_event_counters.sv
// Power unit event counters with an Avalon-MM register slave.
//
// Register access over Avalon-MM and the address map were decided locally.
`include "pwr_events_consts.svh"

module power_unit_event_counters #(
  parameter int NUM_CTR = 4,
  parameter int CTR_W = 48
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic [1:0] avs_response_o,
  input wire pwr_events_pkg::tally_t active_core_tally_i,
  input wire pwr_events_pkg::tally_t sleeping_core_tally_i,
  input wire pwr_events_pkg::band_t uncore_ratio_i,
  input wire logic volt_trans_i,
  input wire logic therm_limit_i,
  input wire logic power_limit_i,
  input wire logic light_cross_limit_i,
  input wire logic heavy_cross_limit_i,
  input wire logic pkg_active_i,
  input wire logic pkg_deep_i,
  input wire logic pkg_transit_i,
  input wire logic mem_shed_i,
  input wire logic cstate_trans_i,
  input wire logic io_limit_i,
  input wire logic freq_change_i
);
  import pwr_events_pkg::*;

  generate
    if (NUM_CTR != 4 || CTR_W <= 32 || CTR_W > 64)
    begin : g_bad_params
      $error("power_unit_event_counters: unsupported parameters");
    end
  endgenerate

  // ****************************************************************
  // Input synchronisers.
  // ****************************************************************
  localparam int NFLAG = 12;
  logic [NFLAG-1:0] flag_meta_reg, flag_reg;
  tally_t act_meta_reg, act_reg, slp_meta_reg, slp_reg;
  band_t ratio_meta_reg, ratio_reg;
  wire logic [NFLAG-1:0] flag_raw = {freq_change_i, io_limit_i,
    cstate_trans_i, mem_shed_i, pkg_transit_i, pkg_deep_i, pkg_active_i,
    heavy_cross_limit_i, light_cross_limit_i, power_limit_i,
    therm_limit_i, volt_trans_i};

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      flag_meta_reg <= '0;
      flag_reg <= '0;
      act_meta_reg <= '0;
      act_reg <= '0;
      slp_meta_reg <= '0;
      slp_reg <= '0;
      ratio_meta_reg <= '0;
      ratio_reg <= '0;
    end
    else if (ce_i)
    begin
      flag_meta_reg <= flag_raw;
      flag_reg <= flag_meta_reg;
      act_meta_reg <= active_core_tally_i;
      act_reg <= act_meta_reg;
      slp_meta_reg <= sleeping_core_tally_i;
      slp_reg <= slp_meta_reg;
      ratio_meta_reg <= uncore_ratio_i;
      ratio_reg <= ratio_meta_reg;
    end
  end

  // ****************************************************************
  // Event selection and counting.
  // ****************************************************************
  logic [31:0] setup_reg [NUM_CTR];
  logic [CTR_W-1:0] count_reg [NUM_CTR];
  logic [31:0] filter_reg;
  logic [NUM_CTR-1:0] cond_prev_reg;
  logic wr_take, rd_take;
  logic [5:0] wr_addr;

  // Returns the per-cycle increment for an event code; unlisted codes add 0.
  function automatic logic [7:0] event_value(input event_code_t sel,
    input logic [NFLAG-1:0] f, input tally_t act, input tally_t slp,
    input logic [31:0] filt, input band_t ratio);
    logic [7:0] v;
    v = 8'h00;
    case (sel)
      `EV_NOTHING: v = 8'h00;
      `EV_CLOCK: v = 8'h01;
      `EV_VOLT_TRANS: v = {7'h00, f[0]};
      `EV_THERM_LIMIT: v = {7'h00, f[1]};
      `EV_POWER_LIMIT: v = {7'h00, f[2]};
      `EV_LIGHT_CROSS: v = {7'h00, f[3]};
      `EV_HEAVY_CROSS: v = {7'h00, f[4]};
      // Residency excludes cycles spent in a package transition.
      `EV_PKG_ACTIVE: v = {7'h00, f[5] & ~f[7]};
      `EV_PKG_DEEP: v = {7'h00, f[6] & ~f[7]};
      `EV_MEM_SHED: v = {7'h00, f[8]};
      `EV_CSTATE_TRANS: v = {7'h00, f[9]};
      `EV_IO_LIMIT: v = {7'h00, f[10]};
      `EV_FREQ_CHANGE: v = {7'h00, f[11]};
      `EV_ACTIVE_TALLY, `EV_OCC_ACTIVE: v = {4'h0, act};
      `EV_SLEEP_TALLY: v = {4'h0, slp};
      // Band events: count while the ratio sits below that band's value.
      `EV_BAND0: v = {7'h00, ratio < filt[7:0]};
      `EV_BAND1: v = {7'h00, ratio < filt[15:8]};
      `EV_BAND2: v = {7'h00, ratio < filt[23:16]};
      `EV_BAND3: v = {7'h00, ratio < filt[31:24]};
      default: v = 8'h00;
    endcase
    return v;
  endfunction : event_value

  logic [7:0] raw_val [NUM_CTR];
  logic [NUM_CTR-1:0] cond_now;
  logic [7:0] inc_val [NUM_CTR];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CTR; gi++)
    begin : g_ctr
      wire logic [7:0] thr = setup_reg[gi][`SETUP_THR_MSB:`SETUP_THR_LSB];
      wire logic inv = setup_reg[gi][`SETUP_INV_BIT];
      wire logic edg = setup_reg[gi][`SETUP_EDGE_BIT];
      wire logic en = setup_reg[gi][`SETUP_EN_BIT];
      always_comb
      begin
        raw_val[gi] = event_value(
          setup_reg[gi][`SETUP_SEL_MSB:`SETUP_SEL_LSB], flag_reg, act_reg,
          slp_reg, filter_reg, ratio_reg);
        // Threshold zero compares against one, so inversion still works.
        if (thr == 8'h00)
          cond_now[gi] = (raw_val[gi] != 8'h00) ^ inv;
        else
          cond_now[gi] = (raw_val[gi] >= thr) ^ inv;
        if (!en)
          inc_val[gi] = 8'h00;
        else if (edg)
          inc_val[gi] = {7'h00, cond_now[gi] & ~cond_prev_reg[gi]};
        else if (thr == 8'h00 && !inv)
          inc_val[gi] = raw_val[gi];
        else
          inc_val[gi] = {7'h00, cond_now[gi]};
      end

      // A disabled counter reads as already high, so enabling it while the
      // condition holds is not mistaken for a transition.
      always_ff @(posedge clk_sys_i)
      begin
        if (srst_i)
          cond_prev_reg[gi] <= 1'b1;
        else if (ce_i)
          cond_prev_reg[gi] <= cond_now[gi] | ~en;
      end

      // Software load wins over counting in the same cycle.
      always_ff @(posedge clk_sys_i)
      begin
        if (srst_i)
          count_reg[gi] <= '0;
        else if (ce_i)
        begin
          if (wr_take && wr_addr == `OFS_COUNT_LO0 + 6'(gi))
            count_reg[gi][31:0] <= avs_writedata_i;
          else if (wr_take && wr_addr == `OFS_COUNT_HI0 + 6'(gi))
            count_reg[gi][CTR_W-1:32] <= avs_writedata_i[CTR_W-33:0];
          else
            count_reg[gi] <= count_reg[gi] +
              CTR_W'(inc_val[gi]);
        end
      end

      always_ff @(posedge clk_sys_i)
      begin
        if (srst_i)
          setup_reg[gi] <= `SETUP_RESET;
        else if (ce_i && wr_take && wr_addr == `OFS_SETUP0 + 6'(gi))
          setup_reg[gi] <= avs_writedata_i;
      end
    end
  endgenerate

  // ****************************************************************
  // Band filter register.
  // ****************************************************************
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      filter_reg <= `FILTER_RESET;
    else if (ce_i && wr_take && wr_addr == `OFS_FILTER_LO)
    begin
      for (int b = 0; b < 4; b++)
        if (avs_byteenable_i[b])
          filter_reg[b*8 +: 8] <= avs_writedata_i[b*8 +: 8];
    end
  end

  // ****************************************************************
  // Avalon-MM slave: one wait cycle, then the answer.
  // ****************************************************************
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [1:0] resp_reg;

  function automatic logic addr_mapped(input logic [5:0] a);
    return (a < `OFS_SETUP0 + 6'(NUM_CTR)) ||
      (a >= `OFS_COUNT_LO0 && a < `OFS_COUNT_LO0 + 6'(NUM_CTR)) ||
      (a >= `OFS_COUNT_HI0 && a < `OFS_COUNT_HI0 + 6'(NUM_CTR)) ||
      (a >= `OFS_FILTER_LO && a <= `OFS_TALLY);
  endfunction : addr_mapped

  assign wr_addr = avs_address_i;
  assign wr_take = avs_write_i && ack_reg && addr_mapped(avs_address_i);
  assign rd_take = avs_read_i && !ack_reg;
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_reg;
  assign avs_readdata_o = rdata_reg;
  assign avs_response_o = resp_reg;

  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    for (int k = 0; k < NUM_CTR; k++)
    begin
      if (avs_address_i == `OFS_SETUP0 + 6'(k))
        rd_mux = setup_reg[k];
      if (avs_address_i == `OFS_COUNT_LO0 + 6'(k))
        rd_mux = count_reg[k][31:0];
      if (avs_address_i == `OFS_COUNT_HI0 + 6'(k))
        rd_mux = {{(64-CTR_W){1'b0}}, count_reg[k][CTR_W-1:32]};
    end
    if (avs_address_i == `OFS_FILTER_LO)
      rd_mux = filter_reg;
    if (avs_address_i == `OFS_TALLY)
      rd_mux = {24'h00_0000, slp_reg, act_reg};
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      resp_reg <= 2'h0;
    end
    else if (ce_i)
    begin
      ack_reg <= (avs_read_i || avs_write_i) && !ack_reg;
      if (rd_take)
        rdata_reg <= rd_mux;
      if ((avs_read_i || avs_write_i) && !ack_reg)
        resp_reg <= addr_mapped(avs_address_i) ? 2'h0 : 2'h2;
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  property p_null_event;
    @(posedge clk_sys_i) disable iff (srst_i)
      ce_i && setup_reg[0][`SETUP_SEL_MSB:`SETUP_SEL_LSB] == `EV_NOTHING &&
      !wr_take
      |=> count_reg[0] == $past(count_reg[0]);
  endproperty
  a_null_event: assert property (p_null_event)
    else $error("null event changed counter 0");

  property p_clock_tick;
    @(posedge clk_sys_i) disable iff (srst_i)
      ce_i && !wr_take && setup_reg[1][`SETUP_SEL_MSB:`SETUP_SEL_LSB] ==
      `EV_CLOCK && setup_reg[1][`SETUP_EN_BIT] &&
      setup_reg[1][`SETUP_THR_MSB:`SETUP_INV_BIT] == 9'h000 &&
      !setup_reg[1][`SETUP_EDGE_BIT]
      |=> count_reg[1] == $past(count_reg[1]) + CTR_W'(1);
  endproperty
  a_clock_tick: assert property (p_clock_tick)
    else $error("clock tick event did not add one");

  property p_disabled_hold;
    @(posedge clk_sys_i) disable iff (srst_i)
      ce_i && !wr_take && !setup_reg[2][`SETUP_EN_BIT]
      |=> $stable(count_reg[2]);
  endproperty
  a_disabled_hold: assert property (p_disabled_hold)
    else $error("disabled counter moved");

  property p_occ_accum;
    @(posedge clk_sys_i) disable iff (srst_i)
      ce_i && !wr_take && setup_reg[0][`SETUP_SEL_MSB:`SETUP_SEL_LSB] ==
      `EV_OCC_ACTIVE && !setup_reg[0][`SETUP_EDGE_BIT] &&
      setup_reg[0][`SETUP_THR_MSB:`SETUP_EN_BIT] == 10'h001
      |=> count_reg[0] == $past(count_reg[0]) + CTR_W'($past(act_reg));
  endproperty
  a_occ_accum: assert property (p_occ_accum)
    else $error("occupancy not accumulated");

  property p_edge_once;
    @(posedge clk_sys_i) disable iff (srst_i)
      ce_i && !wr_take && setup_reg[3][`SETUP_EDGE_BIT] &&
      setup_reg[3][`SETUP_EN_BIT] && cond_prev_reg[3]
      |=> $stable(count_reg[3]);
  endproperty
  a_edge_once: assert property (p_edge_once)
    else $error("edge mode counted a held condition");

  sequence s_req;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  property p_bus_answer;
    @(posedge clk_sys_i) disable iff (srst_i || !ce_i)
      s_req ##1 ce_i |-> !avs_waitrequest_o;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus answer late");

  property p_filter_reserved;
    @(posedge clk_sys_i) disable iff (srst_i)
      avs_read_i && !avs_waitrequest_o && avs_address_i == `OFS_FILTER_HI
      |-> avs_readdata_o == 32'h0000_0000;
  endproperty
  a_filter_reserved: assert property (p_filter_reserved)
    else $error("reserved filter bits nonzero");

  property p_wrap;
    @(posedge clk_sys_i) disable iff (srst_i)
      ce_i && !wr_take && &count_reg[1] && inc_val[1] == 8'h01
      |=> count_reg[1] == '0;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("counter did not wrap");

  property p_inverted_threshold;
    @(posedge clk_sys_i) disable iff (srst_i)
      ce_i && !wr_take && setup_reg[3][`SETUP_EN_BIT] &&
      setup_reg[3][`SETUP_INV_BIT] && !setup_reg[3][`SETUP_EDGE_BIT] &&
      setup_reg[3][`SETUP_THR_MSB:`SETUP_THR_LSB] != 8'h00 &&
      raw_val[3] >= setup_reg[3][`SETUP_THR_MSB:`SETUP_THR_LSB]
      |=> $stable(count_reg[3]);
  endproperty
  a_inverted_threshold: assert property (p_inverted_threshold)
    else $error("inverted threshold counted at or above threshold");
endmodule : power_unit_event_counters

// File: test/pwr_source_model.sv
// Model of the power controller levels that feed the event counters.
module pwr_source_model (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [3:0] len_i,
  input wire logic [11:0] pat_i,
  input wire pwr_events_pkg::tally_t act_i,
  input wire pwr_events_pkg::band_t ratio_i,
  input wire pwr_events_pkg::tally_t idle_act_i,
  input wire pwr_events_pkg::tally_t idle_slp_i,
  output logic [11:0] flags_o = 12'h000,
  output pwr_events_pkg::tally_t act_o = 4'h0,
  output pwr_events_pkg::tally_t slp_o = 4'h0,
  output pwr_events_pkg::band_t ratio_o = 8'hff
);
  timeunit 1ns;
  timeprecision 1ps;
  import pwr_events_pkg::*;
  logic [3:0] left_reg = 4'h0;
  logic burst_on;
  assign burst_on = (left_reg != 4'h0);
  always @(posedge clk_i)
  begin
    if (go_i)
      left_reg <= len_i;
    else if (burst_on)
      left_reg <= left_reg - 4'h1;
  end
  // Levels move only just after an edge and drop back when the burst ends.
  always @(posedge clk_i)
  begin
    flags_o <= burst_on ? pat_i : 12'h000;
    act_o <= burst_on ? act_i : idle_act_i;
    slp_o <= burst_on ? ~act_i : idle_slp_i;
    ratio_o <= burst_on ? ratio_i : 8'hff;
  end
endmodule : pwr_source_model

// File: test/power_unit_event_counters_tb.sv
// Self-checking bench for the power unit event counters.
`include "pwr_events_consts.svh"
module power_unit_event_counters_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pwr_events_pkg::*;
  localparam logic [31:0] EN = 32'h1 << `SETUP_EN_BIT;
  localparam logic [31:0] EDG = 32'h1 << `SETUP_EDGE_BIT;
  localparam logic [31:0] INV = 32'h1 << `SETUP_INV_BIT;
  logic clk_sys_i;
  logic srst_i = 1'b1;
  logic ce_i = 1'b1;
  logic [5:0] avs_address_i = 6'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'hf;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [1:0] avs_response_o;
  logic [11:0] flags;
  logic [11:0] pat_v = 12'h000;
  logic go = 1'b0;
  tally_t act, slp;
  tally_t act_v = 4'h0, idle_act = 4'h0, idle_slp = 4'h0;
  band_t ratio;
  band_t ratio_v = 8'hff;
  band_t band[4];
  int k = 1, compares = 0, miscompares = 0;
  logic [31:0] exp_data[$];
  logic [1:0] exp_resp[$];
  logic [31:0] r;
  logic [7:0] codes[11] = '{`EV_VOLT_TRANS, `EV_THERM_LIMIT,
    `EV_POWER_LIMIT, `EV_LIGHT_CROSS, `EV_HEAVY_CROSS, `EV_PKG_ACTIVE,
    `EV_PKG_DEEP, `EV_MEM_SHED, `EV_CSTATE_TRANS, `EV_IO_LIMIT,
    `EV_FREQ_CHANGE};
  int bits[11] = '{0, 1, 2, 3, 4, 5, 6, 8, 9, 10, 11};

  power_unit_event_counters i_dut (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .ce_i(ce_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .avs_response_o(avs_response_o), .active_core_tally_i(act),
    .sleeping_core_tally_i(slp), .uncore_ratio_i(ratio),
    .volt_trans_i(flags[0]), .therm_limit_i(flags[1]),
    .power_limit_i(flags[2]), .light_cross_limit_i(flags[3]),
    .heavy_cross_limit_i(flags[4]), .pkg_active_i(flags[5]),
    .pkg_deep_i(flags[6]), .pkg_transit_i(flags[7]),
    .mem_shed_i(flags[8]), .cstate_trans_i(flags[9]),
    .io_limit_i(flags[10]), .freq_change_i(flags[11]));

  pwr_source_model i_src (
    .clk_i(clk_sys_i), .go_i(go), .len_i(4'(k)), .pat_i(pat_v),
    .act_i(act_v), .ratio_i(ratio_v), .idle_act_i(idle_act),
    .idle_slp_i(idle_slp), .flags_o(flags), .act_o(act), .slp_o(slp),
    .ratio_o(ratio));

  initial
  begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // ****************************************************************
  // Bus, stimulus and checking tasks
  // ****************************************************************
  task automatic bus(input logic wr, input logic [5:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    @(posedge clk_sys_i);
    while (avs_waitrequest_o !== 1'b0)
      @(posedge clk_sys_i);
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask : wr

  // The expected answer is noted before the read is issued.
  task automatic rd(input logic [5:0] a, input logic [31:0] d,
                    input logic [1:0] rs);
    exp_data.push_back(d);
    exp_resp.push_back(rs);
    bus(1'b0, a, 32'h0, 4'hf);
  endtask : rd

  task automatic burst(input logic [11:0] p, input tally_t a,
                       input band_t rt);
    pat_v <= p;
    act_v <= a;
    ratio_v <= rt;
    go <= 1'b1;
    @(posedge clk_sys_i);
    go <= 1'b0;
    repeat (k + 6) @(posedge clk_sys_i);
  endtask : burst

  task automatic run(input int c, input logic [31:0] s,
    input logic [11:0] p, input tally_t a, input logic [31:0] pl,
    input logic [31:0] ph, input logic [31:0] el, input logic [31:0] eh);
    wr(`OFS_COUNT_LO0 + 6'(c), pl);
    wr(`OFS_COUNT_HI0 + 6'(c), ph);
    wr(`OFS_SETUP0 + 6'(c), s | EN);
    repeat (4) @(posedge clk_sys_i);
    burst(p, a, 8'hff);
    wr(`OFS_SETUP0 + 6'(c), s);
    rd(`OFS_SETUP0 + 6'(c), s, 2'b00);
    rd(`OFS_COUNT_LO0 + 6'(c), el, 2'b00);
    rd(`OFS_COUNT_HI0 + 6'(c), eh, 2'b00);
  endtask : run

  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t data got %h exp %h", $time, got, exp);
    end
  endtask : chk_data

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t resp got %h exp %h", $time, got, exp);
    end
  endtask : chk_resp

  task automatic final_report();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report

  always @(posedge clk_sys_i)
  begin
    if (avs_read_i === 1'b1 && avs_waitrequest_o === 1'b0)
    begin
      chk_data(avs_readdata_o, exp_data.pop_front());
      chk_resp(avs_response_o, exp_resp.pop_front());
    end
  end

  initial
  begin
    #100_000;
    miscompares++;
    final_report();
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    void'($urandom(32'h9984));
    idle_act = 4'h5;
    idle_slp = 4'h9;
    repeat (8) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    rd(`OFS_SETUP0 + 6'h3, `SETUP_RESET, 2'b00);
    rd(`OFS_FILTER_LO, `FILTER_RESET, 2'b00);
    rd(`OFS_COUNT_HI0 + 6'h1, 32'h0, 2'b00);
    rd(6'h3f, 32'h0, 2'b10);
    rd(`OFS_TALLY, 32'h0000_0095, 2'b00);
    idle_act <= 4'h0;
    idle_slp <= 4'h0;
    wr(`OFS_FILTER_LO, 32'h2010_3014);
    r = $urandom;
    bus(1'b1, `OFS_FILTER_LO, r, 4'h2);
    rd(`OFS_FILTER_LO, {16'h2010, r[15:8], 8'h14}, 2'b00);
    wr(`OFS_FILTER_HI, 32'hffff_ffff);
    rd(`OFS_FILTER_HI, 32'h0, 2'b00);
    band = '{8'h14, r[15:8], 8'h10, 8'h20};
    k = $urandom_range(8, 1);
    for (int i = 0; i < 4; i++)
      wr(`OFS_SETUP0 + 6'(i), EN | (32'(`EV_BAND0) + 32'(i)));
    burst(12'h000, 4'h0, 8'h13);
    for (int i = 0; i < 4; i++)
      wr(`OFS_SETUP0 + 6'(i), 32'h0);
    for (int i = 0; i < 4; i++)
      rd(`OFS_COUNT_LO0 + 6'(i), (band[i] > 8'h13) ? 32'(k) : 32'h0,
         2'b00);
    for (int j = 0; j < 11; j++)
    begin
      k = $urandom_range(8, 1);
      run(j % 4, 32'(codes[j]), 12'h1 << bits[j], 4'h0, 0, 0, 32'(k),
          0);
    end
    run(0, `EV_NOTHING, 12'hf7f, 4'h6, 0, 0, 0, 0);
    run(1, 32'h55, 12'hf7f, 4'h6, 0, 0, 0, 0);
    run(1, `EV_CLOCK, 12'h000, 4'h0, 0, 0, 32'(k + 14), 0);
    run(3, `EV_PKG_ACTIVE, 12'h0a0, 4'h0, 0, 0, 0, 0);
    run(0, `EV_PKG_ACTIVE | EDG, 12'h020, 4'h0, 0, 0, 1, 0);
    run(1, `EV_PKG_ACTIVE | EDG | INV, 12'h020, 4'h0, 0, 0, 1, 0);
    run(3, `EV_FREQ_CHANGE | EDG, 12'h800, 4'h0, 0, 0, 1, 0);
    run(3, `EV_ACTIVE_TALLY, 12'h0, 4'h6, 0, 0, 32'(k * 6), 0);
    run(1, `EV_SLEEP_TALLY, 12'h0, 4'h6, 0, 0, 32'(k * 9), 0);
    run(0, `EV_OCC_ACTIVE, 12'h0, 4'h7, 0, 0, 32'(k * 7), 0);
    run(1, `EV_OCC_ACTIVE | 32'h0500_0000, 12'h0, 4'h5, 0, 0, 32'(k),
        0);
    run(2, `EV_OCC_ACTIVE | 32'h0500_0000 | EDG, 12'h0, 4'h6, 0, 0, 1,
        0);
    idle_act <= 4'h4;
    run(3, `EV_OCC_ACTIVE | 32'h0400_0000 | INV, 12'h0, 4'h3, 0, 0,
        32'(k), 0);
    idle_act <= 4'h0;
    k = 3;
    run(1, `EV_VOLT_TRANS, 12'h001, 4'h0, 32'hffff_fffe, 32'h0000_ffff,
        32'h1, 32'h0);
    // Clock enable low for five edges freezes the tick count.
    wr(`OFS_COUNT_LO0 + 6'h2, 32'h0);
    wr(`OFS_SETUP0 + 6'h2, EN | `EV_CLOCK);
    ce_i <= 1'b0;
    repeat (5) @(posedge clk_sys_i);
    ce_i <= 1'b1;
    wr(`OFS_SETUP0 + 6'h2, `EV_CLOCK);
    rd(`OFS_COUNT_LO0 + 6'h2, 32'h3, 2'b00);
    final_report();
  end
endmodule : power_unit_event_counters_tb
